/* rtl/lcd_port_consts.svh */
// Constants for the LCD-shared general-purpose port block.
// Assumes inclusion by bare name from the package, the interface and the top.
`ifndef LCD_PORT_CONSTS_SVH
`define LCD_PORT_CONSTS_SVH

// Port widths and the combined pin vector.
`define COM_W          8
`define SEG_W          5
`define THIRD_W        8
`define PIN_W          21
`define SEG_LSB        8
`define THIRD_LSB      13

// Register byte offsets on the bus.
`define OFS_COM_DATA   8'h00
`define OFS_COM_DIR    8'h04
`define OFS_SEG_DATA   8'h08
`define OFS_SEG_DIR    8'h0c
`define OFS_THR_DATA   8'h10
`define OFS_THR_DIR    8'h14
`define OFS_COM_LATCH  8'h18
`define OFS_SEG_LATCH  8'h1c
`define OFS_THR_LATCH  8'h20
`define OFS_COM_SEL    8'h24
`define OFS_SEG_SEL    8'h28
`define OFS_THR_SEL    8'h2c
`define OFS_PIN_CTRL   8'h30

// Field positions inside the control registers.
`define PORT_INPUT_CONTROL_BIT      0
`define SPL_BIT        1
`define LOW_SEG_LSB    0
`define HIGH_SEG_LSB   2

// Reset values.
`define LATCH_RST8     8'h00
`define LATCH_RST5     5'h00
`define DIR_RST8       8'h00
`define DIR_RST5       5'h00
`define SEL_RST8       8'h00
`define SEL_RST5       5'h00
`define PIN_RST        21'h000000
`define WORD_ZERO      32'h00000000

`endif

/* rtl/lcd_port_pkg.sv */
// Types shared by the LCD-shared general-purpose port block.
// Assumes the constants header sits beside it.
`include "lcd_port_consts.svh"

package lcd_port_pkg;
    typedef logic [31:0]          wb_word_t;
    typedef logic [7:0]           byte_addr_t;
    typedef logic [`COM_W-1:0]    port8_t;
    typedef logic [`SEG_W-1:0]    port5_t;
    typedef logic [`PIN_W-1:0]    pin_vec_t;
endpackage

/* rtl/pin_sync_if.sv */
// Interface carrying raw pin levels to the synchroniser and clean levels back.
// Assumes both ends run on the same CPU clock.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_port_consts.svh"

interface pin_sync_if;
    lcd_port_pkg::pin_vec_t raw;
    lcd_port_pkg::pin_vec_t synced;
    modport source (output raw, input synced);
    modport sync   (input raw, output synced);
endinterface

`default_nettype wire

/* rtl/pin_sync.sv */
// Two-stage synchroniser for every pad input of the port block.
// Assumes raw levels are asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Raw levels in, synchronised levels out.
    pin_sync_if.sync        lvl
);
    lcd_port_pkg::pin_vec_t meta_q, meta_d;
    lcd_port_pkg::pin_vec_t sync_q, sync_d;

    // The first stage feeds only the second stage.
    always_comb begin
        meta_d = lvl.raw;
        sync_d = meta_q;
    end

    // Register both stages; reset clears them to a known low level.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= `PIN_RST;
            sync_q <= `PIN_RST;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign lvl.synced = sync_q;
endmodule // pin_sync

`default_nettype wire

/* rtl/lcd_shared_gpio_ports.sv */
// Three general-purpose ports whose pins are shared with LCD drive lines.
// Assumes a classic Wishbone master on clk_i and a standby level from the
// power controller on the same clock.
//
// Function
// - direction one makes pin drive latch
// - output pin carries its latch bit
// - data write updates latch and outputs
// - output pins read back latch
// - direction zero makes pin an input
// - input pin latch written, not driven
// - input pins read pin; latch view
// - zero means low, one means high
// - common port bits seven..zero map pins
// - segment port uses bits four..zero only
// - common pin GPIO when unselected, control set
// - LCD common needs select and control
// - segment select fields choose pin function
// - reset clears all direction bits
// - standby with pin state one floats
// - standby with pin state zero holds
// - segment pins carry 00,01,37,38,39
// - third port carries segments 02..09
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_port_consts.svh"

module lcd_shared_gpio_ports (
    // Clock and reset.
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Wishbone classic slave.
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    // Standby (stop or watch mode) level from the power controller.
    input  wire logic                   standby_i,
    // Drive values from the LCD controller.
    input  wire logic [`COM_W-1:0]      lcd_com_i,
    input  wire logic [`SEG_W-1:0]      lcd_seg_low_i,
    input  wire logic [`THIRD_W-1:0]    lcd_seg_third_i,
    // Common-shared port pads.
    input  wire logic [`COM_W-1:0]      com_pin_i,
    output logic      [`COM_W-1:0]      com_pin_o,
    output logic      [`COM_W-1:0]      com_pin_oe_o,
    // Segment-shared five-pin port pads.
    input  wire logic [`SEG_W-1:0]      seg_pin_i,
    output logic      [`SEG_W-1:0]      seg_pin_o,
    output logic      [`SEG_W-1:0]      seg_pin_oe_o,
    // Third port pads.
    input  wire logic [`THIRD_W-1:0]    third_pin_i,
    output logic      [`THIRD_W-1:0]    third_pin_o,
    output logic      [`THIRD_W-1:0]    third_pin_oe_o
);

    // Software-visible state.
    lcd_port_pkg::port8_t   com_lat_q, com_lat_d;
    lcd_port_pkg::port8_t   com_dir_q, com_dir_d;
    lcd_port_pkg::port5_t   seg_lat_q, seg_lat_d;
    lcd_port_pkg::port5_t   seg_dir_q, seg_dir_d;
    lcd_port_pkg::port8_t   thr_lat_q, thr_lat_d;
    lcd_port_pkg::port8_t   thr_dir_q, thr_dir_d;
    lcd_port_pkg::port8_t   com_sel_q, com_sel_d;
    lcd_port_pkg::port5_t   seg_sel_q, seg_sel_d;
    lcd_port_pkg::port8_t   thr_sel_q, thr_sel_d;
    logic                   port_input_control_q,   port_input_control_d;
    logic                   spl_q,     spl_d;

    // Bus answer state.
    logic                   ack_q,     ack_d;
    lcd_port_pkg::wb_word_t rdat_q,    rdat_d;

    // Pad drive state.
    lcd_port_pkg::pin_vec_t pout_q,    pout_d;
    lcd_port_pkg::pin_vec_t poe_q,     poe_d;

    // Flattened per-pin views, common port lowest.
    lcd_port_pkg::pin_vec_t lat_all;
    lcd_port_pkg::pin_vec_t dir_all;
    lcd_port_pkg::pin_vec_t sel_all;
    lcd_port_pkg::pin_vec_t lcd_all;
    lcd_port_pkg::pin_vec_t gpio_fn;
    lcd_port_pkg::pin_vec_t lcd_fn;
    lcd_port_pkg::pin_vec_t in_view;
    lcd_port_pkg::pin_vec_t rd_view;
    lcd_port_pkg::pin_vec_t run_oe;
    lcd_port_pkg::pin_vec_t run_out;

    logic                   bus_req;
    logic                   wr_fire;
    logic                   float_w;
    logic                   hold_w;
    lcd_port_pkg::byte_addr_t word_adr;
    logic [7:0]             wd;

    pin_sync_if             pins ();

    // Pad levels are synchronised before any read path sees them.
    assign pins.raw = {third_pin_i, seg_pin_i, com_pin_i};

    pin_sync u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .lvl   (pins.sync)
    );

    // Pin order: bits 7..0 of the common port, then 4..0 of the segment
    // port, then 7..0 of the third port.
    assign lat_all = {thr_lat_q, seg_lat_q, com_lat_q};
    assign dir_all = {thr_dir_q, seg_dir_q, com_dir_q};
    assign sel_all = {thr_sel_q, seg_sel_q, com_sel_q};
    assign lcd_all = {lcd_seg_third_i, lcd_seg_low_i, lcd_com_i};

    // Standby decodes: float every pad, or freeze it as it stands.
    assign float_w = standby_i & spl_q;
    assign hold_w  = standby_i & ~spl_q;

    // Per-pin function selection and read view.
    genvar gi;
    generate
        for (gi = 0; gi < `PIN_W; gi = gi + 1) begin : g_pin
            // General I/O needs the select bit clear and the control bit set.
            assign gpio_fn[gi] = ~sel_all[gi] & port_input_control_q;
            // LCD drive needs the select bit and the control bit both set.
            // The direction bit is ignored here, so a stale one cannot fight
            // the LCD driver.
            assign lcd_fn[gi] = sel_all[gi] & port_input_control_q;
            // Drive enable: a GPIO pin drives when its direction is one; an LCD pin drives whatever its direction.
            assign run_oe[gi] = (gpio_fn[gi] & dir_all[gi]) | lcd_fn[gi];
            // Output value is the latch bit as written, or the LCD line.
            assign run_out[gi] = lcd_fn[gi] ? lcd_all[gi] : lat_all[gi];
            // Inputs are blocked and read low when floated or not GPIO.
            assign in_view[gi] = pins.synced[gi] & gpio_fn[gi] & ~float_w;
            // Normal read: latch for outputs, pad level for inputs.
            assign rd_view[gi] = dir_all[gi] ? lat_all[gi] : in_view[gi];
        end
    endgenerate

    // Pad drive next state, with standby taking precedence.
    always_comb begin
        if (float_w) begin
            poe_d  = `PIN_RST;
            pout_d = pout_q;
        end else if (hold_w) begin
            poe_d  = poe_q;
            pout_d = pout_q;
        end else begin
            poe_d  = run_oe;
            pout_d = run_out;
        end
    end

    // Register the pad drive so every pad output comes from a flip-flop.
    // This costs one cycle between a latch write and the pad edge.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            poe_q  <= `PIN_RST;
            pout_q <= `PIN_RST;
        end else begin
            poe_q  <= poe_d;
            pout_q <= pout_d;
        end
    end

    // Bus decode: a request is answered one cycle after it appears, and a
    // write lands on the very edge at which the master sees the ack.
    assign bus_req  = wb_cyc_i & wb_stb_i;
    assign wr_fire  = bus_req & wb_we_i & ack_q & wb_sel_i[0];
    assign word_adr = {wb_adr_i[7:2], 2'b00};
    assign wd       = wb_dat_i[7:0];

    // Ack and read data next state.
    always_comb begin
        ack_d  = bus_req & ~ack_q;
        rdat_d = `WORD_ZERO;
        case (word_adr)
            `OFS_COM_DATA:  rdat_d[7:0] = rd_view[`COM_W-1:0];
            `OFS_COM_DIR:   rdat_d[7:0] = com_dir_q;
            `OFS_SEG_DATA:  rdat_d[4:0] = rd_view[`THIRD_LSB-1:`SEG_LSB];
            `OFS_SEG_DIR:   rdat_d[4:0] = seg_dir_q;
            `OFS_THR_DATA:  rdat_d[7:0] = rd_view[`PIN_W-1:`THIRD_LSB];
            `OFS_THR_DIR:   rdat_d[7:0] = thr_dir_q;
            // Latch views stand in for read-modify-write reads.
            `OFS_COM_LATCH: rdat_d[7:0] = com_lat_q;
            `OFS_SEG_LATCH: rdat_d[4:0] = seg_lat_q;
            `OFS_THR_LATCH: rdat_d[7:0] = thr_lat_q;
            `OFS_COM_SEL:   rdat_d[7:0] = com_sel_q;
            `OFS_SEG_SEL:   rdat_d[4:0] = seg_sel_q;
            `OFS_THR_SEL:   rdat_d[7:0] = thr_sel_q;
            `OFS_PIN_CTRL: begin
                rdat_d[`PORT_INPUT_CONTROL_BIT] = port_input_control_q;
                rdat_d[`SPL_BIT]   = spl_q;
            end
            // Unmapped words answer with zero and ignore writes.
            default:        rdat_d = `WORD_ZERO;
        endcase
    end

    // Register the bus answer.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= `WORD_ZERO;
        end else begin
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // Register file next state; only byte lane 0 carries data.
    always_comb begin
        com_lat_d = com_lat_q;
        com_dir_d = com_dir_q;
        seg_lat_d = seg_lat_q;
        seg_dir_d = seg_dir_q;
        thr_lat_d = thr_lat_q;
        thr_dir_d = thr_dir_q;
        com_sel_d = com_sel_q;
        seg_sel_d = seg_sel_q;
        thr_sel_d = thr_sel_q;
        port_input_control_d   = port_input_control_q;
        spl_d     = spl_q;
        if (wr_fire) begin
            case (word_adr)
                `OFS_COM_DATA: com_lat_d = wd;
                `OFS_COM_DIR:  com_dir_d = wd;
                // Upper three bits of the segment port have no pins.
                `OFS_SEG_DATA: seg_lat_d = wd[`SEG_W-1:0];
                `OFS_SEG_DIR:  seg_dir_d = wd[`SEG_W-1:0];
                `OFS_THR_DATA: thr_lat_d = wd;
                `OFS_THR_DIR:  thr_dir_d = wd;
                `OFS_COM_SEL:  com_sel_d = wd;
                // Bits 1:0 pick segments 00-01, bits 4:2 segments 37-39.
                `OFS_SEG_SEL:  seg_sel_d = wd[`SEG_W-1:0];
                `OFS_THR_SEL:  thr_sel_d = wd;
                `OFS_PIN_CTRL: begin
                    port_input_control_d = wd[`PORT_INPUT_CONTROL_BIT];
                    spl_d   = wd[`SPL_BIT];
                end
                default: begin
                    com_lat_d = com_lat_q;
                end
            endcase
        end
    end

    // Register file; reset makes every pin an input.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            com_lat_q <= `LATCH_RST8;
            com_dir_q <= `DIR_RST8;
            seg_lat_q <= `LATCH_RST5;
            seg_dir_q <= `DIR_RST5;
            thr_lat_q <= `LATCH_RST8;
            thr_dir_q <= `DIR_RST8;
            com_sel_q <= `SEL_RST8;
            seg_sel_q <= `SEL_RST5;
            thr_sel_q <= `SEL_RST8;
            port_input_control_q   <= 1'b0;
            spl_q     <= 1'b0;
        end else begin
            com_lat_q <= com_lat_d;
            com_dir_q <= com_dir_d;
            seg_lat_q <= seg_lat_d;
            seg_dir_q <= seg_dir_d;
            thr_lat_q <= thr_lat_d;
            thr_dir_q <= thr_dir_d;
            com_sel_q <= com_sel_d;
            seg_sel_q <= seg_sel_d;
            thr_sel_q <= thr_sel_d;
            port_input_control_q   <= port_input_control_d;
            spl_q     <= spl_d;
        end
    end

    // Outputs, all straight from flip-flops. Software must also keep any
    // other peripheral off a pin it uses as general I/O.
    assign wb_ack_o       = ack_q;
    assign wb_dat_o       = rdat_q;
    assign com_pin_o      = pout_q[`COM_W-1:0];
    assign com_pin_oe_o   = poe_q[`COM_W-1:0];
    assign seg_pin_o      = pout_q[`THIRD_LSB-1:`SEG_LSB];
    assign seg_pin_oe_o   = poe_q[`THIRD_LSB-1:`SEG_LSB];
    assign third_pin_o    = pout_q[`PIN_W-1:`THIRD_LSB];
    assign third_pin_oe_o = poe_q[`PIN_W-1:`THIRD_LSB];

endmodule // lcd_shared_gpio_ports

`default_nettype wire

/* dv/gpio_port_chk_asserts.sv */
// Concurrent checks on the port block; the common port is shadowed here.
// Assumes a bind from the bench and sight of the top module's ports only.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_port_consts.svh"

module gpio_port_chk (
    // Clock and reset.
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Bus and mode inputs.
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        standby_i,
    input wire logic [7:0]  lcd_com_i,
    // Pad outputs.
    input wire logic [7:0]  com_pin_o,
    input wire logic [7:0]  com_pin_oe_o,
    input wire logic [4:0]  seg_pin_oe_o,
    input wire logic [7:0]  third_pin_oe_o
);
    logic [7:0] lat_q, dir_q, sel_q, oe_exp, out_exp;
    logic [1:0] ctl_q;
    logic       wr;

    // Expected drive, one cycle ahead of the registered pads.
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign oe_exp = ctl_q[0] ? (sel_q | dir_q) : 8'h00;
    assign out_exp = (sel_q & lcd_com_i) | (~sel_q & lat_q);

    // Shadow registers take writes on the ack edge, as the design does.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lat_q <= 8'h00;
            dir_q <= 8'h00;
            sel_q <= 8'h00;
            ctl_q <= 2'h0;
        end else if (wr) begin
            if (wb_adr_i == `OFS_COM_DATA) lat_q <= wb_dat_i[7:0];
            if (wb_adr_i == `OFS_COM_DIR) dir_q <= wb_dat_i[7:0];
            if (wb_adr_i == `OFS_COM_SEL) sel_q <= wb_dat_i[7:0];
            if (wb_adr_i == `OFS_PIN_CTRL) ctl_q <= wb_dat_i[1:0];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence stby_float_s; standby_i && ctl_q[1]; endsequence
    sequence stby_hold_s; standby_i && !ctl_q[1]; endsequence

    ack_once_a: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack held past one cycle");
    ack_cause_a: assert property (
        wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i)) else $error("ack without request");
    reset_idle_a: assert property (
        $fell(rst_i) |-> com_pin_oe_o == 8'h00 && seg_pin_oe_o == 5'h00
        && third_pin_oe_o == 8'h00) else $error("pad driven after reset");
    oe_func_a: assert property (
        !$past(standby_i) |-> com_pin_oe_o == $past(oe_exp)) else $error("common enable wrong");
    gpio_level_a: assert property (
        !$past(standby_i) |-> ((com_pin_o ^ $past(out_exp)) & $past(oe_exp) & ~$past(sel_q))
        == 8'h00) else $error("common pad not latch");
    com_line_a: assert property (
        !$past(standby_i) |-> ((com_pin_o ^ $past(lcd_com_i)) & $past(oe_exp) & $past(sel_q))
        == 8'h00) else $error("common line mismatch");
    float_stby_a: assert property (
        stby_float_s |=> com_pin_oe_o == 8'h00 && seg_pin_oe_o == 5'h00
        && third_pin_oe_o == 8'h00) else $error("pad driven in standby");
    hold_stby_a: assert property (
        stby_hold_s |=> $stable(com_pin_oe_o) && $stable(com_pin_o)) else $error("pad moved in standby");
endmodule // gpio_port_chk

`default_nettype wire

/* dv/board_pads.sv */
// Board side of one pad group: device drive wins, then the board, else float.
// Assumes the bench may leave board drivers on where the device drives.
`timescale 1ns/1ps
`default_nettype none

module board_pads #(
    parameter int W = 8
) (
    // Clock.
    input  wire logic         clk_i,
    // Device drive.
    input  wire logic [W-1:0] oe_i,
    input  wire logic [W-1:0] o_i,
    // Board drive and resolved level.
    input  wire logic [W-1:0] ext_i,
    input  wire logic [W-1:0] ext_en_i,
    output logic      [W-1:0] pad_o
);
    logic [W-1:0] pat_q = '0;

    // No pull exists, so an undriven pad wanders instead of keeping its level.
    always_ff @(posedge clk_i) pat_q <= ~pat_q;

    // Resolve every bit from all drivers.
    assign pad_o = (oe_i & o_i) | (~oe_i & ext_en_i & ext_i) | (~oe_i & ~ext_en_i & pat_q);
endmodule // board_pads

`default_nettype wire

/* dv/lcd_shared_gpio_ports_tb.sv */
// Self-checking bench with a register model for the port block.
// Assumes the checker and board pad model are compiled ahead of it.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_port_consts.svh"

module lcd_shared_gpio_ports_tb;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, stby = 1'b0;
    logic        ack;
    logic [7:0]  adr = 8'h00, hold_oe, hold_o;
    logic [3:0]  sel = 4'hf;
    logic [31:0] dat = 32'h0, dat_o, rdat;
    logic [7:0]  lcd[3] = '{default: 8'h00}, ext[3] = '{default: 8'h00};
    logic [7:0]  ext_en[3] = '{default: 8'hff}, lat[3] = '{default: 8'h00};
    logic [7:0]  dir[3] = '{default: 8'h00}, fsel[3] = '{default: 8'h00};
    wire  [7:0]  oe_v[3], o_v[3], pad_v[3];
    logic [1:0]  ctl = 2'h0;
    int          failures = 0, comparisons = 0, seed = 47;

    always #10 clk_i = ~clk_i;

    lcd_shared_gpio_ports uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .standby_i(stby), .lcd_com_i(lcd[0]), .lcd_seg_low_i(lcd[1][4:0]),
        .lcd_seg_third_i(lcd[2]), .com_pin_i(pad_v[0]), .com_pin_o(o_v[0]),
        .com_pin_oe_o(oe_v[0]), .seg_pin_i(pad_v[1][4:0]), .seg_pin_o(o_v[1][4:0]),
        .seg_pin_oe_o(oe_v[1][4:0]), .third_pin_i(pad_v[2]), .third_pin_o(o_v[2]),
        .third_pin_oe_o(oe_v[2]));

    // One board model per port; segment bits above four stay unused.
    for (genvar p = 0; p < 3; p++) begin : g_pad
        board_pads #(.W(8)) pads (.clk_i(clk_i), .oe_i(oe_v[p]), .o_i(o_v[p]),
            .ext_i(ext[p]), .ext_en_i(ext_en[p]), .pad_o(pad_v[p]));
    end

    function automatic logic [7:0] mk(input int p);
        return (p == 1) ? 8'h1f : 8'hff;
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // Classic cycle: hold everything until ack is sampled, then release.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        chk("ack", 32'h1, {31'h0, ack});
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // Write and keep the model in step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d});
        for (int p = 0; p < 3; p++) begin
            if (a == 8'(`OFS_COM_DATA + 8 * p)) lat[p] = d & mk(p);
            if (a == 8'(`OFS_COM_DIR + 8 * p)) dir[p] = d & mk(p);
            if (a == 8'(`OFS_COM_SEL + 4 * p)) fsel[p] = d & mk(p);
        end
        if (a == `OFS_PIN_CTRL) ctl = d[1:0];
    endtask

    task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, {24'h0, e}, rdat);
    endtask

    task automatic pins(input int p);
        logic [7:0] e;
        e = ctl[0] ? (fsel[p] | dir[p]) : 8'h00;
        chk("pin_oe", {24'h0, e}, {24'h0, oe_v[p] & mk(p)});
        chk("pin_out", {24'h0, e & ((fsel[p] & lcd[p]) | (~fsel[p] & lat[p]))}, {24'h0, e & o_v[p]});
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // A run should take well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk_i);
        failures++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int p = 0; p < 3; p++) begin
            rd("dir_rst", 8'(`OFS_COM_DIR + 8 * p), 8'h00);
            rd("in_off", 8'(`OFS_COM_DATA + 8 * p), 8'h00);
            pins(p);
        end
        wr(`OFS_PIN_CTRL, 8'h01);
        bus(1'b1, 8'h3c, 32'hff);
        rd("unmapped", 8'h3c, 8'h00);
        rd("ctrl", `OFS_PIN_CTRL, 8'h01);
        // A write without byte lane 0 is acked but must leave the latch alone.
        sel <= 4'he;
        bus(1'b1, `OFS_COM_DATA, 32'h5a);
        sel <= 4'hf;
        rd("sel_off", `OFS_COM_LATCH, lat[0]);
        // Random directions, selects and data; selected pins keep direction clear.
        repeat (8) begin
            for (int p = 0; p < 3; p++) begin
                wr(8'(`OFS_COM_DIR + 8 * p), 8'($random(seed)));
                wr(8'(`OFS_COM_SEL + 4 * p), 8'($random(seed)) & ~dir[p]);
                wr(8'(`OFS_COM_DATA + 8 * p), 8'($random(seed)));
                lcd[p] <= 8'($random(seed));
                ext[p] <= 8'($random(seed));
            end
            repeat (4) @(posedge clk_i);
            for (int p = 0; p < 3; p++) begin
                pins(p);
                rd("data", 8'(`OFS_COM_DATA + 8 * p), (dir[p] & lat[p]) | (~dir[p] & ~fsel[p] & ext[p] & mk(p)));
                rd("latch", 8'(`OFS_COM_LATCH + 4 * p), lat[p]);
            end
        end
        // Standby with floating pads: board lets go, inputs must read low.
        wr(`OFS_PIN_CTRL, 8'h03);
        stby <= 1'b1;
        for (int p = 0; p < 3; p++) ext_en[p] <= 8'h00;
        repeat (4) @(posedge clk_i);
        for (int p = 0; p < 3; p++) begin
            chk("float_oe", 32'h0, {24'h0, oe_v[p] & mk(p)});
            rd("float_in", 8'(`OFS_COM_DATA + 8 * p), dir[p] & lat[p]);
        end
        stby <= 1'b0;
        for (int p = 0; p < 3; p++) ext_en[p] <= 8'hff;
        // Standby with held pads: latch and line changes must not reach them.
        wr(`OFS_PIN_CTRL, 8'h01);
        wr(`OFS_COM_DIR, 8'hf0);
        wr(`OFS_COM_SEL, 8'h0f);
        repeat (4) @(posedge clk_i);
        hold_oe = oe_v[0];
        hold_o = o_v[0];
        stby <= 1'b1;
        lcd[0] <= ~lcd[0];
        wr(`OFS_COM_DATA, ~lat[0]);
        repeat (4) @(posedge clk_i);
        chk("hold_oe", {24'h0, hold_oe}, {24'h0, oe_v[0]});
        chk("hold_out", {24'h0, hold_o}, {24'h0, o_v[0]});
        stby <= 1'b0;
        repeat (4) @(posedge clk_i);
        pins(0);
        wr(`OFS_PIN_CTRL, 8'h00);
        repeat (4) @(posedge clk_i);
        for (int p = 0; p < 3; p++) pins(p);
        tally_and_finish();
    end
endmodule // lcd_shared_gpio_ports_tb

bind lcd_shared_gpio_ports gpio_port_chk chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .standby_i(standby_i),
    .lcd_com_i(lcd_com_i), .com_pin_o(com_pin_o), .com_pin_oe_o(com_pin_oe_o),
    .seg_pin_oe_o(seg_pin_oe_o), .third_pin_oe_o(third_pin_oe_o));

`default_nettype wire
